// File: rtl/serial_port_pkg.sv
// Register map, field positions and types of the serial port control block
package serial_port_pkg;
  localparam logic [3:0]  CTRL_OFFSET         = 4'h0;
  localparam logic [3:0]  CTRL_TWO_OFFSET     = 4'h4;
  localparam logic [3:0]  STATUS_OFFSET       = 4'h8;
  localparam logic [3:0]  RX_DATA_OFFSET      = 4'hC;
  localparam logic [31:0] CTRL_RESET          = 32'h0000_0000;
  localparam logic [31:0] CTRL_TWO_RESET      = 32'h0000_0000;
  localparam logic [2:0]  STATUS_RESET        = 3'h0;
  localparam logic [31:0] CTRL_WRITE_MASK     = 32'hFF83_BFFF;
  localparam logic [31:0] CTRL_LOCK_MASK      = 32'h0081_0000;
  localparam logic [31:0] CTRL_TWO_WRITE_MASK = 32'h0000_9F8B;
  localparam logic [31:0] CTRL_TWO_LOCK_MASK  = 32'h0000_008B;
  // Control register fields
  localparam int FRAMED_ENABLE_BIT      = 31;
  localparam int SYNC_DIRECTION_BIT     = 30;
  localparam int SYNC_POLARITY_BIT      = 29;
  localparam int AUTO_SLAVE_SELECT_BIT  = 28;
  localparam int SYNC_PULSE_WIDTH_BIT   = 27;
  localparam int SYNC_COUNT_LSB         = 24;
  localparam int BAUD_SOURCE_BIT        = 23;
  localparam int ENHANCED_BUFFER_BIT    = 16;
  localparam int MODULE_ON_BIT          = 15;
  localparam int WORD32_BIT             = 11;
  localparam int WORD16_BIT             = 10;
  localparam int CLOCK_EDGE_BIT         = 8;
  localparam int CLOCK_IDLE_POL_BIT     = 6;
  localparam int MASTER_ENABLE_BIT      = 5;
  // Second control register fields
  localparam int RX_SIGN_EXTEND_BIT     = 15;
  localparam int FRAME_ERR_EVENT_BIT    = 12;
  localparam int OVERFLOW_EVENT_BIT     = 11;
  localparam int UNDERRUN_EVENT_BIT     = 10;
  localparam int TOLERATE_OVERFLOW_BIT  = 9;
  localparam int TOLERATE_UNDERRUN_BIT  = 8;
  localparam int AUDIO_ENABLE_BIT       = 7;
  localparam int MONO_SELECT_BIT        = 3;
  localparam int AUDIO_FORMAT_LSB       = 0;
  // Status register fields
  localparam int STAT_FRAME_ERROR_BIT   = 0;
  localparam int STAT_OVERFLOW_BIT      = 1;
  localparam int STAT_UNDERRUN_BIT      = 2;
  localparam int STAT_HALTED_BIT        = 3;
  localparam logic [2:0] SYNC_COUNT_MAX_CODE = 3'h5;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  localparam logic [1:0] FORMAT_I2S     = 2'h0;
  typedef enum logic [1:0] {FS_IDLE = 2'b01, FS_PULSE = 2'b10} frame_sync_signal_state_t;
endpackage

// File: rtl/framed_audio_serial_port_control.sv
// Control registers, frame sync and error handling of the serial port
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Framed enable turns slave select into sync
// - Direction bit set makes sync an input
// - Polarity bit picks active-high or active-low pulse
// - Master auto select drives pin during transfers
// - Width bit: one character or one bit
// - Sync every 1 to 32 characters
// - Baud source: reference or peripheral bus clock
// - Locked fields writable only while module off
// - Audio mode forces clock idle polarity high
// - Sign extend receive words when enabled
// - Frame error event gated by enable bit
// - Overflow event gated by enable bit
// - Underrun event gated by enable bit
// - Tolerated overflow keeps data, else halts
// - Tolerated underrun sends zeros, else halts
// - Audio enable selects audio protocol operation
// - Mono sends each word on both channels
// - Format codes: I2S, left, right, PCM/DSP
// - Mono and format only act in audio mode
module framed_audio_serial_port_control #(
  parameter int DATA_W = 32
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              char_start,
  input  wire logic              char_done,
  input  wire logic              bit_tick,
  input  wire logic              transfer_active,
  input  wire logic              frame_error_detect,
  input  wire logic              rx_word_valid,
  input  wire logic              rx_fifo_full,
  input  wire logic [DATA_W-1:0] rx_fifo_word,
  input  wire logic              tx_buffer_empty,
  input  wire logic [DATA_W-1:0] tx_buffer_word,
  input  wire logic              slave_select_in,
  output logic                   slave_select_out,
  output logic                   slave_select_oe,
  output logic                   frame_sync_seen,
  output logic                   serial_run,
  output logic                   baud_use_reference,
  output logic                   enhanced_buffer,
  output logic                   clock_idle_polarity,
  output logic                   clock_edge_select,
  output logic                   audio_mode,
  output logic                   mono_duplicate,
  output logic [1:0]             audio_format,
  output logic                   rx_store,
  output logic [DATA_W-1:0]      tx_shift_word,
  output logic                   error_event
);
  logic [31:0]         ctrl_ff;
  logic [31:0]         ctrl_two_ff;
  logic [2:0]          status_ff;
  logic                halt_ff;
  logic                aw_held_ff;
  logic                w_held_ff;
  logic [3:0]          aw_addr_ff;
  logic [31:0]         w_data_ff;
  logic [3:0]          w_strb_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                rvalid_ff;
  logic [31:0]         rdata_ff;
  logic [1:0]          rresp_ff;
  logic                error_event_ff;
  logic [DATA_W-1:0]   tx_shift_word_ff;
  logic                frame_sync_seen_ff;
  logic [4:0]          char_cnt_ff;
  serial_port_pkg::frame_sync_signal_state_t fs_state_ff;
  serial_port_pkg::frame_sync_signal_state_t nxt_fs_state;
  logic                wr_go;
  logic [31:0]         wr_mask;
  logic [31:0]         nxt_ctrl;
  logic [31:0]         nxt_ctrl_two;
  logic                module_on;
  logic                framed;
  logic                sync_pol;
  logic                master;
  logic                fs_master;
  logic                fs_fire;
  logic                fs_end;
  logic                overflow;
  logic                underrun;
  logic [4:0]          sync_period_m1;
  logic [2:0]          status_clear;

  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic [DATA_W-1:0] rx_extend(
    input logic [DATA_W-1:0] w, input logic sx,
    input logic w32, input logic w16);
    logic [DATA_W-1:0] r;
    r = w;
    if (!w32 && w16)
    begin
      r = {{(DATA_W-16){sx & w[15]}}, w[15:0]};
    end
    else if (!w32)
    begin
      r = {{(DATA_W-8){sx & w[7]}}, w[7:0]};
    end
    return r;
  endfunction

  assign module_on = ctrl_ff[serial_port_pkg::MODULE_ON_BIT];
  assign framed    = ctrl_ff[serial_port_pkg::FRAMED_ENABLE_BIT];
  assign sync_pol  = ctrl_ff[serial_port_pkg::SYNC_POLARITY_BIT];
  assign master    = ctrl_ff[serial_port_pkg::MASTER_ENABLE_BIT];
  assign fs_master = framed
                   & ~ctrl_ff[serial_port_pkg::SYNC_DIRECTION_BIT];

  // AXI write path: address and data are caught in either order
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign wr_go         = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_mask       = strobe_mask(w_strb_ff);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= serial_port_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (aw_addr_ff == serial_port_pkg::RX_DATA_OFFSET)
                    ? serial_port_pkg::RESP_SLVERR
                    : serial_port_pkg::RESP_OKAY;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Locked fields keep their value while the module is on
  always_comb
  begin
    logic [31:0] m1;
    logic [31:0] m2;
    m1 = wr_mask & serial_port_pkg::CTRL_WRITE_MASK;
    m2 = wr_mask & serial_port_pkg::CTRL_TWO_WRITE_MASK;
    if (module_on)
    begin
      m1 = m1 & ~serial_port_pkg::CTRL_LOCK_MASK;
      m2 = m2 & ~serial_port_pkg::CTRL_TWO_LOCK_MASK;
    end
    nxt_ctrl     = (ctrl_ff & ~m1) | (w_data_ff & m1);
    nxt_ctrl_two = (ctrl_two_ff & ~m2) | (w_data_ff & m2);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff     <= serial_port_pkg::CTRL_RESET;
      ctrl_two_ff <= serial_port_pkg::CTRL_TWO_RESET;
    end
    else if (wr_go && aw_addr_ff == serial_port_pkg::CTRL_OFFSET)
    begin
      ctrl_ff <= nxt_ctrl;
    end
    else if (wr_go && aw_addr_ff == serial_port_pkg::CTRL_TWO_OFFSET)
    begin
      ctrl_two_ff <= nxt_ctrl_two;
    end
  end

  // AXI read path
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= serial_port_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= serial_port_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        serial_port_pkg::CTRL_OFFSET:     rdata_ff <= ctrl_ff;
        serial_port_pkg::CTRL_TWO_OFFSET: rdata_ff <= ctrl_two_ff;
        serial_port_pkg::STATUS_OFFSET:   rdata_ff <= {28'h0, halt_ff, status_ff};
        serial_port_pkg::RX_DATA_OFFSET:
          rdata_ff <= 32'(rx_extend(rx_fifo_word,
            ctrl_two_ff[serial_port_pkg::RX_SIGN_EXTEND_BIT],
            ctrl_ff[serial_port_pkg::WORD32_BIT],
            ctrl_ff[serial_port_pkg::WORD16_BIT]));
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= serial_port_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  // Configuration seen by the serial engine
  assign baud_use_reference  = ctrl_ff[serial_port_pkg::BAUD_SOURCE_BIT];
  assign enhanced_buffer     = ctrl_ff[serial_port_pkg::ENHANCED_BUFFER_BIT];
  assign audio_mode          = ctrl_two_ff[serial_port_pkg::AUDIO_ENABLE_BIT];
  assign clock_idle_polarity = audio_mode
                             | ctrl_ff[serial_port_pkg::CLOCK_IDLE_POL_BIT];
  // Edge select has no meaning while framed
  assign clock_edge_select   = ~framed
                             & ctrl_ff[serial_port_pkg::CLOCK_EDGE_BIT];
  assign mono_duplicate      = audio_mode
                             & ctrl_two_ff[serial_port_pkg::MONO_SELECT_BIT];
  assign audio_format        = audio_mode
    ? ctrl_two_ff[serial_port_pkg::AUDIO_FORMAT_LSB +: 2]
    : serial_port_pkg::FORMAT_I2S;

  // Error detection and halting
  assign overflow   = rx_word_valid & rx_fifo_full & serial_run;
  assign underrun   = char_start & tx_buffer_empty & serial_run;
  assign serial_run = module_on & ~halt_ff;
  assign rx_store   = rx_word_valid & ~rx_fifo_full & serial_run;
  assign status_clear = (wr_go && aw_addr_ff == serial_port_pkg::STATUS_OFFSET
                         && w_strb_ff[0]) ? w_data_ff[2:0] : 3'h0;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halt_ff <= 1'b0;
    end
    else if (!module_on)
    begin
      halt_ff <= 1'b0;
    end
    else if ((overflow
              && !ctrl_two_ff[serial_port_pkg::TOLERATE_OVERFLOW_BIT])
          || (underrun
              && !ctrl_two_ff[serial_port_pkg::TOLERATE_UNDERRUN_BIT]))
    begin
      halt_ff <= 1'b1;
    end
  end

  // Sticky flags, cleared by writing one; a new event wins the clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_ff <= serial_port_pkg::STATUS_RESET;
    end
    else
    begin
      status_ff <= (status_ff & ~status_clear)
                 | {underrun, overflow, frame_error_detect};
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      error_event_ff <= 1'b0;
    end
    else
    begin
      error_event_ff <=
          (frame_error_detect
           & ctrl_two_ff[serial_port_pkg::FRAME_ERR_EVENT_BIT])
        | (overflow & ctrl_two_ff[serial_port_pkg::OVERFLOW_EVENT_BIT])
        | (underrun & ctrl_two_ff[serial_port_pkg::UNDERRUN_EVENT_BIT]);
    end
  end
  assign error_event = error_event_ff;

  // Empty transmit buffer sends zeros
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_shift_word_ff <= '0;
    end
    else if (char_start)
    begin
      tx_shift_word_ff <= tx_buffer_empty ? '0 : tx_buffer_word;
    end
  end
  assign tx_shift_word = tx_shift_word_ff;

  // Frame sync generator: one pulse per programmed number of characters
  always_comb
  begin
    unique case (ctrl_ff[serial_port_pkg::SYNC_COUNT_LSB +: 3])
      3'h0:    sync_period_m1 = 5'h00;
      3'h1:    sync_period_m1 = 5'h01;
      3'h2:    sync_period_m1 = 5'h03;
      3'h3:    sync_period_m1 = 5'h07;
      3'h4:    sync_period_m1 = 5'h0F;
      default: sync_period_m1 = 5'h1F;
    endcase
  end

  assign fs_fire = fs_master & serial_run & char_start & (char_cnt_ff == 5'h00);
  assign fs_end  = ctrl_ff[serial_port_pkg::SYNC_PULSE_WIDTH_BIT]
                 ? char_done : bit_tick;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      char_cnt_ff <= 5'h00;
    end
    else if (!fs_master || !serial_run)
    begin
      char_cnt_ff <= 5'h00;
    end
    else if (char_start)
    begin
      char_cnt_ff <= (char_cnt_ff == 5'h00) ? sync_period_m1
                                            : char_cnt_ff - 5'h01;
    end
  end

  always_comb
  begin
    nxt_fs_state = fs_state_ff;
    unique case (fs_state_ff)
      serial_port_pkg::FS_IDLE:
        if (fs_fire) nxt_fs_state = serial_port_pkg::FS_PULSE;
      serial_port_pkg::FS_PULSE:
        if (fs_end || !fs_master) nxt_fs_state = serial_port_pkg::FS_IDLE;
      default:  nxt_fs_state = serial_port_pkg::FS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fs_state_ff <= serial_port_pkg::FS_IDLE;
    end
    else
    begin
      fs_state_ff <= nxt_fs_state;
    end
  end

  // Slave select pin: frame sync out, automatic select, or released
  always_comb
  begin
    slave_select_oe  = 1'b0;
    slave_select_out = ~sync_pol;
    if (fs_master)
    begin
      slave_select_oe  = 1'b1;
      slave_select_out = (fs_state_ff == serial_port_pkg::FS_PULSE)
                       ? sync_pol : ~sync_pol;
    end
    else if (!framed && master
          && ctrl_ff[serial_port_pkg::AUTO_SLAVE_SELECT_BIT])
    begin
      slave_select_oe  = 1'b1;
      slave_select_out = transfer_active ? sync_pol : ~sync_pol;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_sync_seen_ff <= 1'b0;
    end
    else
    begin
      frame_sync_seen_ff <= framed
        & ctrl_ff[serial_port_pkg::SYNC_DIRECTION_BIT]
        & (slave_select_in == sync_pol);
    end
  end
  assign frame_sync_seen = frame_sync_seen_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence ctrl_write_while_on;
    wr_go && aw_addr_ff == serial_port_pkg::CTRL_OFFSET && module_on;
  endsequence
  sequence sync_fires;
    fs_fire && fs_state_ff == serial_port_pkg::FS_IDLE;
  endsequence

  chk_lock_baud_src: assert property (ctrl_write_while_on |=>
    baud_use_reference == $past(baud_use_reference))
    else $error("baud source changed while module on");
  chk_idle_pol_audio: assert property (audio_mode |-> clock_idle_polarity)
    else $error("idle polarity not forced in audio mode");
  chk_sync_input_dir: assert property ((framed
    && ctrl_ff[serial_port_pkg::SYNC_DIRECTION_BIT]) |-> !slave_select_oe)
    else $error("sync pin driven in sync input role");
  chk_sync_bit_width: assert property ((bit_tick
    && fs_state_ff == serial_port_pkg::FS_PULSE
    && !ctrl_ff[serial_port_pkg::SYNC_PULSE_WIDTH_BIT])
    |=> fs_state_ff == serial_port_pkg::FS_IDLE)
    else $error("bit wide sync pulse did not end");
  chk_sync_pulse_level: assert property (sync_fires |=>
    slave_select_oe && slave_select_out == sync_pol)
    else $error("sync pulse level wrong");
  chk_sync_count_one: assert property ((fs_master && serial_run && char_start
    && ctrl_ff[serial_port_pkg::SYNC_COUNT_LSB +: 3] == 3'h1
    && char_cnt_ff == 5'h00) |=> char_cnt_ff == 5'h01)
    else $error("sync count reload wrong");
  chk_overflow_halt: assert property ((overflow
    && !ctrl_two_ff[serial_port_pkg::TOLERATE_OVERFLOW_BIT]) |=> !serial_run)
    else $error("critical overflow did not halt");
  chk_underrun_zeros: assert property ((char_start && tx_buffer_empty) |=>
    tx_shift_word == '0)
    else $error("underrun did not send zeros");
  chk_overflow_event: assert property ((overflow
    && ctrl_two_ff[serial_port_pkg::OVERFLOW_EVENT_BIT]) |=> error_event)
    else $error("overflow event missing");
  chk_format_gated: assert property (!audio_mode |->
    (audio_format == serial_port_pkg::FORMAT_I2S && !mono_duplicate))
    else $error("audio options active outside audio mode");
endmodule
`default_nettype wire

// File: bench/serial_engine_model.sv
// Behavioural serial engine facing the control block
`timescale 1ns/1ps
`default_nettype none
module serial_engine_model (
  input  wire logic   clock,
  output logic        char_start,
  output logic        char_done,
  output logic        bit_tick,
  output logic        transfer_active,
  output logic        frame_error_detect,
  output logic        rx_word_valid,
  output logic        rx_fifo_full,
  output logic [31:0] rx_fifo_word,
  output logic        tx_buffer_empty,
  output logic [31:0] tx_buffer_word,
  output logic        slave_select_in
);
  initial
  begin
    {char_start, char_done, bit_tick, transfer_active} = 4'h0;
    {frame_error_detect, rx_word_valid, rx_fifo_full} = 3'h0;
    {tx_buffer_empty, slave_select_in} = 2'h0;
    rx_fifo_word = 32'h0000_0000;
    tx_buffer_word = 32'h0000_0000;
  end
  // One character: start, a gap, two bit clocks, end of character
  task chr();
    @(posedge clock) char_start <= 1'b1;
    @(posedge clock) char_start <= 1'b0;
    @(posedge clock) bit_tick <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    bit_tick <= 1'b0;
    char_done <= 1'b1;
    @(posedge clock) char_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, tx_shift_word, rd;
  logic [31:0] rx_fifo_word, tx_buffer_word;
  logic [1:0]  s_axi_bresp, s_axi_rresp, audio_format, resp;
  logic clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, char_start;
  logic char_done, bit_tick, transfer_active, frame_error_detect;
  logic rx_word_valid, rx_fifo_full, tx_buffer_empty, slave_select_in;
  logic slave_select_out, slave_select_oe, frame_sync_seen, serial_run;
  logic baud_use_reference, enhanced_buffer, clock_idle_polarity;
  logic clock_edge_select, audio_mode, mono_duplicate, rx_store;
  logic error_event, pol_exp, act, act_d;
  int err_total, tests_run, ev_cnt, fs_cnt, hi_cnt, cyc, n, e0, w[2];
  int cd[3] = '{0, 1, 5};
  int nch[3] = '{4, 4, 33};
  int npl[3] = '{4, 2, 2};
  framed_audio_serial_port_control #(.DATA_W(32)) DUT (
    .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .char_start, .char_done, .bit_tick,
    .transfer_active, .frame_error_detect, .rx_word_valid,
    .rx_fifo_full, .rx_fifo_word, .tx_buffer_empty, .tx_buffer_word,
    .slave_select_in, .slave_select_out, .slave_select_oe,
    .frame_sync_seen, .serial_run, .baud_use_reference,
    .enhanced_buffer, .clock_idle_polarity, .clock_edge_select,
    .audio_mode, .mono_duplicate, .audio_format, .rx_store,
    .tx_shift_word, .error_event);
  serial_engine_model eng (
    .clock, .char_start, .char_done, .bit_tick, .transfer_active,
    .frame_error_detect, .rx_word_valid, .rx_fifo_full, .rx_fifo_word,
    .tx_buffer_empty, .tx_buffer_word, .slave_select_in);
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Counts error events, sync pulses and active cycles; cuts hangs
  always @(negedge clock)
  begin
    cyc++;
    if (error_event === 1'b1) ev_cnt++;
    act = slave_select_oe === 1'b1 && slave_select_out === pol_exp;
    if (act) hi_cnt++;
    if (act && !act_d) fs_cnt++;
    act_d = act;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    tests_run++;
    if (seen !== ex)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  // Accesses start a cycle apart, even right after clearing on
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic at, wt, bt;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge clock);
      at = s_axi_awready;
      wt = s_axi_wready;
      bt = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clock);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
    end while (!bt);
    s_axi_bready <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] ex, input string nm);
    logic at, rt;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge clock);
      at = s_axi_arready;
      rt = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      if (at) s_axi_arvalid <= 1'b0;
    end while (!rt);
    s_axi_rready <= 1'b0;
    chk(nm, rd, ex);
  endtask
  task ovf();
    e0 = ev_cnt;
    eng.rx_word_valid <= 1'b1;
    @(negedge clock);
    chk("rx store", rx_store, 1'b0);
    @(posedge clock);
    eng.rx_word_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  initial
  begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, pol_exp, act_d} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00F;
    s_axi_wdata = 32'h0000_0000;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rchk(4'h0, serial_port_pkg::CTRL_RESET, "control");
    rchk(4'h4, serial_port_pkg::CTRL_TWO_RESET, "control two");
    rchk(4'h2, 32'h0000_0000, "unmapped data");
    chk("unmapped resp", resp, serial_port_pkg::RESP_SLVERR);
    wr(4'hC, 32'h0000_0001);
    chk("rx data resp", resp, serial_port_pkg::RESP_SLVERR);
    $display("test reset done");
    for (n = 0; n < 4; n++)
    begin
      wr(4'h4, 32'h0000_0088 | n);
      chk("format", audio_format, n);
      chk("mono", mono_duplicate, 1'b1);
      chk("audio", audio_mode, 1'b1);
      chk("idle pol", clock_idle_polarity, 1'b1);
    end
    wr(4'h0, 32'h0081_8000);
    chk("baud ref", baud_use_reference, 1'b1);
    chk("enh buf", enhanced_buffer, 1'b1);
    wr(4'h4, 32'h0000_0000);
    rchk(4'h4, 32'h0000_008B, "locked two");
    wr(4'h0, 32'h0000_8000);
    rchk(4'h0, 32'h0081_8000, "locked one");
    wr(4'h0, 32'h0000_0000);
    wr(4'h4, 32'h0000_0008);
    chk("mono off", mono_duplicate, 1'b0);
    chk("audio off", audio_mode, 1'b0);
    chk("idle off", clock_idle_polarity, 1'b0);
    $display("test config done");
    wr(4'h4, 32'h0000_1C00);
    wr(4'h0, 32'h0000_8000);
    eng.rx_fifo_full <= 1'b1;
    ovf();
    chk("ovf event", ev_cnt - e0, 1);
    chk("ovf halt", serial_run, 1'b0);
    rchk(4'h8, 32'h0000_000A, "status");
    wr(4'h0, 32'h0000_0000);
    wr(4'h8, 32'h0000_0007);
    wr(4'h4, 32'h0000_0300);
    wr(4'h0, 32'h0000_8000);
    ovf();
    chk("ovf quiet", ev_cnt - e0, 0);
    chk("ovf run", serial_run, 1'b1);
    eng.rx_fifo_full <= 1'b0;
    eng.tx_buffer_empty <= 1'b1;
    eng.tx_buffer_word <= 32'h5A5A_5A5A;
    eng.chr();
    chk("tx zero", tx_shift_word, 32'h0000_0000);
    chk("tur run", serial_run, 1'b1);
    eng.tx_buffer_empty <= 1'b0;
    eng.chr();
    chk("tx word", tx_shift_word, 32'h5A5A_5A5A);
    wr(4'h4, 32'h0000_0400);
    e0 = ev_cnt;
    eng.tx_buffer_empty <= 1'b1;
    eng.chr();
    chk("tur event", ev_cnt - e0, 1);
    chk("tur halt", serial_run, 1'b0);
    eng.tx_buffer_empty <= 1'b0;
    for (n = 1; n >= 0; n--)
    begin
      wr(4'h4, 32'h0000_1000 * n);
      e0 = ev_cnt;
      eng.frame_error_detect <= 1'b1;
      @(posedge clock);
      eng.frame_error_detect <= 1'b0;
      repeat (3) @(posedge clock);
      chk("frame event", ev_cnt - e0, n);
    end
    eng.rx_fifo_word <= 32'h0000_0080;
    wr(4'h4, 32'h0000_8000);
    rchk(4'hC, 32'hFFFF_FF80, "rx signed");
    wr(4'h4, 32'h0000_0000);
    rchk(4'hC, 32'h0000_0080, "rx plain");
    wr(4'h0, 32'h0000_8400);
    wr(4'h4, 32'h0000_8000);
    rchk(4'hC, 32'h0000_0080, "rx half");
    $display("test errors done");
    for (n = 0; n < 6; n++)
    begin
      wr(4'h0, 32'h0000_0000);
      pol_exp = n / 3;
      wr(4'h0, 32'h8000_8000 | (n / 3) << 29 | cd[n % 3] << 24);
      chk("sync drive", slave_select_oe, 1'b1);
      e0 = fs_cnt;
      repeat (nch[n % 3]) eng.chr();
      repeat (3) @(posedge clock);
      chk("sync pulses", fs_cnt - e0, npl[n % 3]);
    end
    for (n = 0; n < 2; n++)
    begin
      wr(4'h0, 32'h0000_0000);
      wr(4'h0, 32'hA000_8000 | n << 27);
      e0 = hi_cnt;
      eng.chr();
      repeat (3) @(posedge clock);
      w[n] = hi_cnt - e0;
    end
    chk("width order", w[1] > w[0] && w[0] > 0, 1'b1);
    wr(4'h0, 32'h0000_0000);
    wr(4'h0, 32'hE000_8000);
    chk("sync input", slave_select_oe, 1'b0);
    eng.slave_select_in <= 1'b1;
    repeat (2) @(posedge clock);
    chk("sync seen", frame_sync_seen, 1'b1);
    eng.slave_select_in <= 1'b0;
    wr(4'h0, 32'h0000_0000);
    wr(4'h0, 32'h1000_8020);
    eng.transfer_active <= 1'b1;
    repeat (2) @(posedge clock);
    chk("auto drive", slave_select_oe, 1'b1);
    chk("auto level", slave_select_out, 1'b0);
    wr(4'h0, 32'h0000_8120);
    chk("auto off", slave_select_oe, 1'b0);
    chk("edge sel", clock_edge_select, 1'b1);
    $display("test frame done");
    end_of_test();
  end
endmodule
`default_nettype wire
